// ===== src/spimsc_core.sv
// SPI master/slave core: registers, baud divider, shift engine, pins.
// Assumes the register port runs on clk; pin inputs are asynchronous.
`timescale 1ns/1ns
`default_nettype none

// Contract
// - Half period is (pre+1)*2^sel clocks.
// - Divisor spans 2 to 2048 per fields.
// - Status writes ignored, reads always allowed.
// - Received byte sets done flag bit 7.
// - Done clears by status read, data read.
// - Tx-empty flag bit 5 while buffer free.
// - Data write accepted only after armed read.
// - Low select as master sets fault bit 4.
// - Fault clears by status read, ctrl1 write.
// - Fault drops master, outputs off, aborts transfer.
// - Queued byte starts after previous completes.
// - Unread byte kept; later bytes discarded.
// - Double-buffered receive; one shared data address.
// - Enable dedicates select, clock, data pins.
// - Eight bit shifts exchange master, slave bytes.
// - Polarity inverts clock; phase picks sample edge.
// - Master-select bit picks master or slave.
// - Only master starts, on data write.
// - Byte loads shifter when empty, as master at once, as slave once selected.
// - Select leads first clock edge by a full serial period.
// - Baud change as master aborts to idle.
module spimsc_core
  import spimsc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire spimsc_req_type req,
  output logic [7:0] rdata,
  // Serial pins
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic miso_i,
  input wire logic ss_n_i,
  output spimsc_pin_out_type pins,
  // Interrupt request
  output logic irq
);
  logic [7:0] ctrl1_r, ctrl2_r, baud_r, rxbuf_r, txbuf_r, shift_r;
  logic done_r, txe_r, fault_r, done_arm_r, txe_arm_r, fault_arm_r;
  logic txfull_r, sck_r, sampled_r, ss_drv_r;
  logic [3:0] bitcnt_r;
  logic [4:0] edgecnt_r;
  logic [10:0] divcnt_r;
  spimsc_state_type state_r;
  logic [2:0] sck_s, mosi_s, miso_s, ss_s;

  // Half of the full divisor, since each half period is one edge
  function automatic logic [10:0] half_div(input logic [7:0] b);
    half_div = 11'((({8'h0, b[BAUD_PRE_LSB +: 3]} + 11'h1)) << b[BAUD_SEL_LSB +: 3]);
  endfunction

  // One shift step; shared by engine and receive capture
  function automatic logic [7:0] shift_in(input logic [7:0] s, input logic b, input logic l);
    shift_in = l ? {b, s[7:1]} : {s[6:0], b};
  endfunction

  wire wr_c1 = req.wr && req.addr == ADDR_CTRL1;
  wire wr_c2 = req.wr && req.addr == ADDR_CTRL2;
  wire wr_bd = req.wr && req.addr == ADDR_BAUD;
  wire rd_sr = req.rd && req.addr == ADDR_STATUS;
  wire rd_dr = req.rd && req.addr == ADDR_DATA;
  wire wr_dr = req.wr && req.addr == ADDR_DATA;
  wire enabled = ctrl1_r[CR1_EN];
  wire master = ctrl1_r[CR1_MASTER_SELECT_BIT];
  wire clock_polarity_bit = ctrl1_r[CR1_CLOCK_POLARITY_BIT];
  wire clock_phase_bit = ctrl1_r[CR1_CLOCK_PHASE_BIT];
  wire lsbf = ctrl1_r[CR1_LSBF];

  // Three-stage synchronisers; stage 2 and 3 are safe for logic and edges
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sck_s <= 3'h0;
      mosi_s <= 3'h0;
      miso_s <= 3'h0;
      ss_s <= 3'h7;
    end else begin
      sck_s <= {sck_s[1:0], sck_i};
      mosi_s <= {mosi_s[1:0], mosi_i};
      miso_s <= {miso_s[1:0], miso_i};
      ss_s <= {ss_s[1:0], ss_n_i};
    end
  end
  wire ss_low = !ss_s[1];
  wire sck_edge = sck_s[2] != sck_s[1];
  wire fault_ev = enabled && master && ctrl2_r[CR2_FDEN] && !ctrl1_r[CR1_SSOE] && ss_low;
  wire baud_chg = wr_bd && ((req.wdata & BAUD_MASK) != baud_r) && master;
  wire c1_abort = wr_c1 && master && (req.wdata[3:0] != ctrl1_r[3:0]);
  wire m_abort = fault_ev || baud_chg || c1_abort || !enabled;
  wire s_abort = !master && ss_s[1];
  wire tx_accept = wr_dr && txe_arm_r;
  wire done_clr = rd_dr && done_arm_r;

  // Engine events
  logic tick, last_edge, is_sample, xfer_done;
  always_comb begin
    tick = (state_r != SPIMSC_IDLE) && master && divcnt_r == 11'h1;
    is_sample = (edgecnt_r[0] == clock_phase_bit);
    last_edge = edgecnt_r == 5'd15;
    xfer_done = 1'b0;
    if (master) begin
      xfer_done = state_r == SPIMSC_SHIFT && tick && last_edge;
    end else begin
      xfer_done = state_r == SPIMSC_SHIFT && sck_edge && last_edge && !ss_s[1];
    end
  end

  // Control registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl1_r <= CTRL1_RST;
      ctrl2_r <= CTRL2_RST;
      baud_r <= BAUD_RST;
    end else begin
      if (wr_c1) begin
        ctrl1_r <= req.wdata;
      end
      if (fault_ev) begin
        ctrl1_r[CR1_MASTER_SELECT_BIT] <= 1'b0;
      end
      if (wr_c2) begin
        ctrl2_r <= req.wdata & CR2_MASK;
      end
      if (wr_bd) begin
        baud_r <= req.wdata & BAUD_MASK;
      end
    end
  end

  // Status flags; hardware set wins over a software clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_r <= 1'b0;
      fault_r <= 1'b0;
      done_arm_r <= 1'b0;
      fault_arm_r <= 1'b0;
      txe_arm_r <= 1'b0;
    end else begin
      if (rd_sr) begin
        done_arm_r <= done_r;
        fault_arm_r <= fault_r;
        txe_arm_r <= txe_r;
      end
      if (done_clr) begin
        done_r <= 1'b0;
        done_arm_r <= 1'b0;
      end
      if (xfer_done) begin
        done_r <= 1'b1;
      end
      if (wr_c1 && fault_arm_r) begin
        fault_r <= 1'b0;
        fault_arm_r <= 1'b0;
      end
      if (fault_ev) begin
        fault_r <= 1'b1;
      end
      if (wr_dr) begin
        txe_arm_r <= 1'b0;
      end
    end
  end

  // Receive buffer holds first unread byte
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxbuf_r <= 8'h00;
    end else if (xfer_done && (!done_r || done_clr)) begin
      // With phase 0 the last shift lands on this same edge, so capture the shifted value
      rxbuf_r <= shift_in(shift_r, sampled_r, lsbf);
    end
  end

  // Transmit buffer and empty flag
  logic load_shift;
  always_comb begin
    load_shift = txfull_r && state_r == SPIMSC_IDLE && enabled && (master || !ss_s[1]);
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txbuf_r <= 8'h00;
      txfull_r <= 1'b0;
      txe_r <= 1'b1;
    end else begin
      if (load_shift) begin
        txfull_r <= 1'b0;
        txe_r <= 1'b1;
      end
      if (tx_accept) begin
        txbuf_r <= req.wdata;
        txfull_r <= 1'b1;
        txe_r <= 1'b0;
      end
    end
  end

  // Shift engine: master counts half periods, slave follows the clock pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= SPIMSC_IDLE;
      shift_r <= 8'h00;
      edgecnt_r <= 5'h0;
      divcnt_r <= 11'h1;
      sck_r <= 1'b0;
      sampled_r <= 1'b0;
      ss_drv_r <= 1'b1;
    end else begin
      case (state_r)
        SPIMSC_IDLE: begin
          sck_r <= 1'b0;
          edgecnt_r <= 5'h0;
          ss_drv_r <= 1'b1;
          divcnt_r <= half_div(baud_r);
          if (load_shift) begin
            shift_r <= txbuf_r;
            ss_drv_r <= !master;
            state_r <= master ? SPIMSC_LEAD : SPIMSC_SHIFT;
          end
        end
        SPIMSC_LEAD: begin
          ss_drv_r <= 1'b0;
          if (divcnt_r == 11'h1) begin
            divcnt_r <= half_div(baud_r);
            state_r <= SPIMSC_SHIFT;
          end else begin
            divcnt_r <= divcnt_r - 11'h1;
          end
        end
        SPIMSC_SHIFT: begin
          if (master) begin
            divcnt_r <= tick ? half_div(baud_r) : divcnt_r - 11'h1;
          end
          if ((master && tick) || (!master && sck_edge)) begin
            sck_r <= !sck_r;
            edgecnt_r <= edgecnt_r + 5'h1;
            if (is_sample) begin
              sampled_r <= master ? miso_s[2] : mosi_s[2];
            end else begin
              shift_r <= shift_in(shift_r, sampled_r, lsbf);
            end
            if (last_edge) begin
              state_r <= SPIMSC_IDLE;
            end
          end
          if (clock_phase_bit && edgecnt_r == 5'h0 && is_sample) begin
            sampled_r <= sampled_r;
          end
        end
        default: state_r <= SPIMSC_IDLE;
      endcase
      if ((master && m_abort) || (!master && s_abort && state_r != SPIMSC_IDLE)) begin
        state_r <= SPIMSC_IDLE;
        sck_r <= 1'b0;
        ss_drv_r <= 1'b1;
      end
    end
  end

  // Outgoing bit depends on order; the last shift completes byte on edge 16
  logic out_bit;
  always_comb begin
    out_bit = lsbf ? shift_r[0] : shift_r[7];
  end

  // Pin drivers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pins <= '0;
      pins.ss_o <= 1'b1;
    end else begin
      pins.sck_o <= sck_r ^ clock_polarity_bit;
      pins.sck_oe <= enabled && master && !fault_ev;
      pins.mosi_o <= out_bit;
      pins.mosi_oe <= enabled && master && !fault_ev;
      pins.miso_o <= out_bit;
      pins.miso_oe <= enabled && !master && ss_low && !fault_r;
      pins.ss_o <= ss_drv_r;
      pins.ss_oe <= enabled && master && ctrl1_r[CR1_SSOE] && ctrl2_r[CR2_FDEN];
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (req.rd) begin
      case (req.addr)
        ADDR_CTRL1: rdata <= ctrl1_r;
        ADDR_CTRL2: rdata <= ctrl2_r;
        ADDR_BAUD: rdata <= baud_r;
        ADDR_STATUS: rdata <= {done_r, 1'b0, txe_r, fault_r, 4'h0};
        ADDR_DATA: rdata <= rxbuf_r;
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= (ctrl1_r[CR1_IE] && (done_r || fault_r)) || (ctrl1_r[CR1_TXIE] && txe_r);
    end
  end

  AST_STATUS_RO: assert property (@(posedge clk) disable iff (rst)
    (req.wr && req.addr == ADDR_STATUS) |=> $stable(ctrl1_r) || $past(fault_ev))
    else $error("status write changed control");
  AST_DONE_SET: assert property (@(posedge clk) disable iff (rst)
    xfer_done |=> done_r) else $error("done flag not set");
  AST_DONE_CLR: assert property (@(posedge clk) disable iff (rst)
    ($fell(done_r)) |-> $past(rd_dr && done_arm_r)) else $error("done cleared wrongly");
  AST_TX_REFUSE: assert property (@(posedge clk) disable iff (rst)
    (wr_dr && !txe_arm_r && !load_shift) |=> $stable(txbuf_r)) else $error("write not ignored");
  AST_FAULT: assert property (@(posedge clk) disable iff (rst)
    fault_ev |=> fault_r && !ctrl1_r[CR1_MASTER_SELECT_BIT]) else $error("fault not taken");
  AST_FAULT_IDLE: assert property (@(posedge clk) disable iff (rst)
    fault_ev |=> state_r == SPIMSC_IDLE ##1 !pins.sck_oe) else $error("fault no abort");
  AST_KEEP_RX: assert property (@(posedge clk) disable iff (rst)
    (done_r && !(rd_dr && done_arm_r)) |=> $stable(rxbuf_r)) else $error("unread byte lost");
  AST_BAUD_ABORT: assert property (@(posedge clk) disable iff (rst)
    baud_chg |=> state_r == SPIMSC_IDLE) else $error("baud change no abort");
  AST_LEAD: assert property (@(posedge clk) disable iff (rst)
    (state_r == SPIMSC_IDLE && load_shift && master && !m_abort) |=>
    state_r == SPIMSC_LEAD) else $error("no half period lead");
endmodule

`default_nettype wire

// ===== include/spimsc_pkg.sv
// Package for the byte-wide SPI master/slave core.
// Assumes one 25 MHz clock and a plain register port with 3-bit addresses.
package spimsc_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  // Register offsets
  localparam logic [2:0] ADDR_CTRL1 = 3'h0;
  localparam logic [2:0] ADDR_CTRL2 = 3'h1;
  localparam logic [2:0] ADDR_BAUD = 3'h2;
  localparam logic [2:0] ADDR_STATUS = 3'h3;
  localparam logic [2:0] ADDR_DATA = 3'h5;
  // First control register fields
  localparam int CR1_IE = 7;
  localparam int CR1_EN = 6;
  localparam int CR1_TXIE = 5;
  localparam int CR1_MASTER_SELECT_BIT = 4;
  localparam int CR1_CLOCK_POLARITY_BIT = 3;
  localparam int CR1_CLOCK_PHASE_BIT = 2;
  localparam int CR1_SSOE = 1;
  localparam int CR1_LSBF = 0;
  // Second control register fields
  localparam int CR2_FDEN = 4;
  // Baud fields
  localparam int BAUD_PRE_LSB = 4;
  localparam int BAUD_SEL_LSB = 0;
  localparam logic [7:0] BAUD_MASK = 8'h77;
  localparam logic [7:0] CR2_MASK = 8'h10;
  // Status fields
  localparam int SR_DONE = 7;
  localparam int SR_TXE = 5;
  localparam int SR_FAULT = 4;
  // Reset values
  localparam logic [7:0] CTRL1_RST = 8'h04;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [1:0] {
    SPIMSC_IDLE = 2'b00,
    SPIMSC_LEAD = 2'b01,
    SPIMSC_SHIFT = 2'b10
  } spimsc_state_type;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } spimsc_req_type;

  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
    logic ss_o;
    logic ss_oe;
  } spimsc_pin_out_type;
endpackage

// ===== dv/spimsc_slave_model.sv
// Remote SPI slave: mode 0, MSB first, keeps shifting across bytes.
// Assumes the core is master and drives clock and select.
`timescale 1ns/1ns
`default_nettype none
module spimsc_slave_model (
  // Pins
  input wire logic ss_n,
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  // Bench side
  input wire logic [7:0] tx,
  output logic [7:0] rx,
  output int cnt
);
  logic [7:0] sh;
  int n;
  initial begin
    miso = 1'b0;
    rx = 8'h00;
    cnt = 0;
  end
  always @(negedge ss_n) begin
    sh = tx;
    n = 0;
    miso = tx[7];
  end
  // Only answers; it never makes a clock
  always @(posedge sck) begin
    if (!ss_n) begin
      sh = {sh[6:0], mosi};
      n++;
      if (n == 8) begin
        rx = sh;
        cnt++;
        n = 0;
      end
    end
  end
  always @(negedge sck) begin
    if (!ss_n) begin
      miso = sh[7];
    end
  end
  // Released line must not look stable
  always @(posedge ss_n) begin
    miso = ~miso;
  end
endmodule
`default_nettype wire

// ===== dv/spimsc_core_bench.sv
// Bench for the SPI core as master against a slave model.
// Assumes 25 MHz clk and the register port of the package.
`timescale 1ns/1ns
`default_nettype none
module spimsc_core_bench;
  import spimsc_pkg::*;
  logic clk;
  logic rst;
  spimsc_req_type req;
  logic [7:0] rdata;
  spimsc_pin_out_type pins;
  logic irq;
  logic tb_ss;
  logic s_miso;
  logic [7:0] stx;
  logic [7:0] srx;
  int scnt;
  int fails;
  int compares;
  wire logic ss_w = pins.ss_oe ? pins.ss_o : tb_ss;
  wire logic sck_w = pins.sck_oe ? pins.sck_o : 1'b0;
  wire logic mosi_w = pins.mosi_oe ? pins.mosi_o : 1'b1;
  wire logic miso_w = pins.miso_oe ? pins.miso_o : s_miso;

  spimsc_core u_dut (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .sck_i(sck_w),
    .mosi_i(mosi_w), .miso_i(miso_w), .ss_n_i(ss_w), .pins(pins), .irq(irq));
  spimsc_slave_model u_slave (.ss_n(ss_w), .sck(sck_w), .mosi(mosi_w), .miso(s_miso),
    .tx(stx), .rx(srx), .cnt(scnt));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic rdchk(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(16'(d), 16'(e));
  endtask
  // Select high again marks the end of the whole queue
  task automatic wait_xfer(input int n);
    int k;
    k = 0;
    while ((scnt < n || pins.ss_o !== 1'b1) && k < 40000) begin
      @(posedge clk);
      k++;
    end
    repeat (4) @(posedge clk);
  endtask

  task automatic t_regs;
    rdchk(ADDR_STATUS, 8'h20);
    wr(ADDR_STATUS, 8'hff);
    rdchk(ADDR_STATUS, 8'h20);
    rdchk(3'h7, 8'h00);
    wr(ADDR_CTRL2, CR2_MASK);
    chk(16'(irq), 16'h0000);
    wr(ADDR_CTRL1, 8'h72);
    repeat (2) @(posedge clk);
    chk(16'(irq), 16'h0001);
    wr(ADDR_CTRL1, 8'h52);
    rdchk(ADDR_CTRL1, 8'h52);
  endtask
  task automatic t_xfer;
    logic [7:0] bauds [3];
    int halves [3];
    logic [7:0] d;
    logic s;
    int k;
    bauds = '{8'h60, 8'h03, 8'h77};
    halves = '{7, 8, 1024};
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_BAUD, bauds[i]);
      stx = 8'h3c ^ 8'(i);
      rd(ADDR_STATUS, d);
      wr(ADDR_DATA, 8'ha5 + 8'(i));
      for (int e = 0; e < 2; e++) begin
        s = pins.sck_o;
        k = 0;
        while (pins.sck_o === s && k < 5000) begin
          @(negedge clk);
          k++;
        end
      end
      chk(16'(k), 16'(halves[i]));
      wait_xfer(i + 1);
      chk(16'(srx), 16'(8'ha5 + 8'(i)));
      rdchk(ADDR_DATA, 8'h3c ^ 8'(i));
      rdchk(ADDR_STATUS, 8'ha0);
      rdchk(ADDR_DATA, 8'h3c ^ 8'(i));
      rdchk(ADDR_STATUS, 8'h20);
    end
  endtask
  // Two queued bytes; second reception must be dropped
  task automatic t_queue;
    logic [7:0] d;
    wr(ADDR_BAUD, 8'h60);
    stx = 8'h3c;
    rd(ADDR_STATUS, d);
    wr(ADDR_DATA, 8'h11);
    rdchk(ADDR_STATUS, 8'h20);
    wr(ADDR_DATA, 8'h22);
    wr(ADDR_DATA, 8'h33);
    rdchk(ADDR_STATUS, 8'h00);
    stx = 8'h5a;
    wait_xfer(5);
    repeat (300) @(posedge clk);
    chk(16'(scnt), 16'd5);
    chk(16'(srx), 16'h0022);
    rdchk(ADDR_STATUS, 8'ha0);
    rdchk(ADDR_DATA, 8'h3c);
  endtask
  task automatic t_fault;
    logic [7:0] d;
    int k;
    wr(ADDR_CTRL1, 8'h50);
    tb_ss <= 1'b0;
    k = 0;
    d = 8'h00;
    while (d[4] !== 1'b1 && k < 20) begin
      rd(ADDR_STATUS, d);
      k++;
    end
    chk(16'(d[4]), 16'h0001);
    chk(16'({pins.sck_oe, pins.mosi_oe, pins.miso_oe, pins.ss_oe}), 16'h0000);
    rdchk(ADDR_CTRL1, 8'h40);
    tb_ss <= 1'b1;
    repeat (4) @(posedge clk);
    rd(ADDR_STATUS, d);
    wr(ADDR_CTRL1, 8'h52);
    rd(ADDR_STATUS, d);
    chk(16'(d[4]), 16'h0000);
  endtask

  task automatic end_sim;
    $display("Mismatches %0d of %0d comparisons", fails, compares);
    if (fails == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    req = '0;
    tb_ss = 1'b1;
    stx = 8'h3c;
    fails = 0;
    compares = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_xfer;
    t_queue;
    t_fault;
    end_sim;
  end
  // Longest run is about 20k cycles
  initial begin
    #(40 * 90000);
    fails++;
    end_sim;
  end
endmodule
`default_nettype wire
